// file: design/frt_timer.sv
/*
  Free-running 16-bit timer with prescaler, external count input,
  two count views with byte latch, rollover flag and request.
  Assumes a classic Wishbone master on CLK_SYS and that the
  external count input is asynchronous to CLK_SYS.
*/
// Contract
// [RQ1] Sixteen-bit up-counter fed by a prescaler
// [RQ2] Prescaler divides CPU clock by 2, 4, 8
// [RQ3] External count at least four times slower
// [RQ4] Two views return the same count on reads
// [RQ5] Writing either low byte reloads FFFC
// [RQ6] Reset loads FFFC, the only reload value
// [RQ7] Software reads high byte before low byte
// [RQ8] High byte read latches low byte until read
// [RQ9] Later lone low read returns live byte
// [RQ10] Wrap FFFF to 0000 sets rollover flag
// [RQ11] Request needs enable set, global mask clear
// [RQ12] Clear: status read, then primary low access
// [RQ13] Shadow low accesses never clear flag
// [RQ14] Counting continues in idle sleep
// [RQ15] Deep stop freezes count, resumes after wake
// [RQ16] Unbonded count input reads as one
// [RQ17] Both select bits one pick external input
// [RQ18] Edge select picks active external transition
// [RQ19] External counting synchronised to CPU clock
// [RQ20] Each tick adds one, wrapping to zero
`timescale 1ns/1ps
`default_nettype none
module frt_timer #(
  parameter bit EXT_PIN_BONDED = 1'b1
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output var  logic [31:0] WB_DAT_O,
  output var  logic        WB_ACK_O,
  input  wire logic        EXT_COUNT_IN,
  input  wire logic        GLOBAL_IRQ_MASK,
  input  wire logic        IDLE_SLEEP,
  input  wire logic        DEEP_STOP,
  output var  logic        TIMER_IRQ
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0] cnt;
    logic [2:0]  presc;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_s3;
    logic        flag;
    logic        armed;
    logic [7:0]  latch;
    logic        latch_valid;
    logic        irq_en;
    logic [1:0]  psel;
    logic        edge_sel;
    logic        ack;
    logic [31:0] dat;
    logic        irq;
  } frt_state_t;

  frt_state_t s_reg;
  frt_state_t s_next;
  logic       acc;
  logic       rd;
  logic       wr;
  logic       tick;
  logic       ext_edge;
  logic [2:0] div_mask;

  // Register decode shared by reads, writes and side effects
  function automatic logic is_ofs(input logic [7:0] adr, input logic [7:0] ofs);
    is_ofs = (adr == ofs);
  endfunction

  // Bus request taken once per transfer, ack follows next cycle
  assign acc = WB_CYC_I && WB_STB_I && !s_reg.ack;
  assign rd  = acc && !WB_WE_I;
  assign wr  = acc && WB_WE_I;

  // Prescaler mask for the internal divide ratios
  // [RQ2] ratio select
  always_comb
  begin
    case (s_reg.psel)
      frt_pkg::PSEL_DIV2: div_mask = frt_pkg::MASK_DIV2;
      frt_pkg::PSEL_DIV4: div_mask = frt_pkg::MASK_DIV4;
      frt_pkg::PSEL_DIV8: div_mask = frt_pkg::MASK_DIV8;
      default:            div_mask = frt_pkg::MASK_DIV8;
    endcase
  end

  // Active edge from the synchronised external input
  // [RQ18] edge choice
  assign ext_edge = s_reg.edge_sel ? (s_reg.ext_s2 && !s_reg.ext_s3)
                                   : (!s_reg.ext_s2 && s_reg.ext_s3);

  // Count tick; idle sleep has no effect, deep stop freezes
  // [RQ14] idle ignored
  // [RQ17] external select
  assign tick = CE && !DEEP_STOP &&
                ((s_reg.psel == frt_pkg::PSEL_EXT) ? ext_edge
                 : ((s_reg.presc & div_mask) == div_mask));

  // Next-state logic
  always_comb
  begin
    s_next = s_reg;
    // Sample external pin; an unbonded pin reads one
    // [RQ16] unbonded high
    // [RQ19] clock-aligned sampling
    s_next.ext_s1 = EXT_PIN_BONDED ? EXT_COUNT_IN : 1'b1;
    s_next.ext_s2 = s_reg.ext_s1;
    s_next.ext_s3 = s_reg.ext_s2;
    // [RQ15] stop freezes prescaler
    if (!DEEP_STOP)
    begin
      s_next.presc = s_reg.presc + 3'h1;
    end
    // [RQ1] up-counter
    // [RQ20] increment by one
    if (tick)
    begin
      s_next.cnt = s_reg.cnt + 16'h0001;
    end
    // Handshake and read data
    s_next.ack = acc;
    s_next.dat = 32'h0000_0000;
    if (rd)
    begin
      // [RQ4] identical views
      if (is_ofs(WB_ADR_I, frt_pkg::OFS_COUNT_HIGH) ||
          is_ofs(WB_ADR_I, frt_pkg::OFS_SHADOW_HIGH))
      begin
        s_next.dat[7:0] = s_reg.cnt[15:8];
        // [RQ8] latch low byte
        if (!s_reg.latch_valid)
        begin
          s_next.latch = s_reg.cnt[7:0];
        end
        s_next.latch_valid = 1'b1;
      end
      else if (is_ofs(WB_ADR_I, frt_pkg::OFS_COUNT_LOW) ||
               is_ofs(WB_ADR_I, frt_pkg::OFS_SHADOW_LOW))
      begin
        // [RQ9] live byte after sequence
        s_next.dat[7:0]    = s_reg.latch_valid ? s_reg.latch : s_reg.cnt[7:0];
        s_next.latch_valid = 1'b0;
      end
      else if (is_ofs(WB_ADR_I, frt_pkg::OFS_STATUS))
      begin
        s_next.dat[frt_pkg::BIT_ROLLOVER_FLAG] = s_reg.flag;
        // [RQ12] first clear step
        if (s_reg.flag)
        begin
          s_next.armed = 1'b1;
        end
      end
      else if (is_ofs(WB_ADR_I, frt_pkg::OFS_FIRST_CTRL))
      begin
        s_next.dat[frt_pkg::BIT_ROLLOVER_IRQ_EN] = s_reg.irq_en;
      end
      else if (is_ofs(WB_ADR_I, frt_pkg::OFS_SECOND_CTRL))
      begin
        s_next.dat[frt_pkg::BIT_PSEL_LO +: 2]     = s_reg.psel;
        s_next.dat[frt_pkg::BIT_EDGE_SELECT]      = s_reg.edge_sel;
      end
    end
    if (wr && WB_SEL_I[0])
    begin
      // [RQ5] reload on low write
      // [RQ6] single reload value
      if (is_ofs(WB_ADR_I, frt_pkg::OFS_COUNT_LOW) ||
          is_ofs(WB_ADR_I, frt_pkg::OFS_SHADOW_LOW))
      begin
        s_next.cnt = frt_pkg::COUNT_RELOAD;
      end
      else if (is_ofs(WB_ADR_I, frt_pkg::OFS_FIRST_CTRL))
      begin
        s_next.irq_en = WB_DAT_I[frt_pkg::BIT_ROLLOVER_IRQ_EN];
      end
      else if (is_ofs(WB_ADR_I, frt_pkg::OFS_SECOND_CTRL))
      begin
        s_next.psel     = WB_DAT_I[frt_pkg::BIT_PSEL_LO +: 2];
        s_next.edge_sel = WB_DAT_I[frt_pkg::BIT_EDGE_SELECT];
      end
    end
    // Second clear step on primary low only, shadow never clears
    // [RQ12] second clear step
    // [RQ13] shadow leaves flag
    if (acc && s_reg.armed && is_ofs(WB_ADR_I, frt_pkg::OFS_COUNT_LOW))
    begin
      s_next.flag  = 1'b0;
      s_next.armed = 1'b0;
    end
    // Rollover sets the flag and wins over a clear
    // [RQ10] wrap sets flag
    if (tick && (s_reg.cnt == frt_pkg::COUNT_MAX))
    begin
      s_next.flag = 1'b1;
    end
    // Request stays pending until enabled and unmasked
    // [RQ11] gated request
    s_next.irq = s_reg.flag && s_reg.irq_en && !GLOBAL_IRQ_MASK;
  end

  // State register, frozen while CE is low
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      s_reg     <= '0;
      s_reg.cnt <= frt_pkg::COUNT_RELOAD;
      s_reg.ext_s1 <= 1'b1;
      s_reg.ext_s2 <= 1'b1;
      s_reg.ext_s3 <= 1'b1;
    end
    else if (CE)
    begin
      s_reg <= s_next;
    end
  end

  assign WB_DAT_O  = s_reg.dat;
  assign WB_ACK_O  = s_reg.ack;
  assign TIMER_IRQ = s_reg.irq;

  // ==========================================================
  // Assertions
  sequence s_hi_read;
    CE && rd && (is_ofs(WB_ADR_I, frt_pkg::OFS_COUNT_HIGH) ||
                 is_ofs(WB_ADR_I, frt_pkg::OFS_SHADOW_HIGH));
  endsequence

  sequence s_status_seen;
    CE && rd && s_reg.flag && is_ofs(WB_ADR_I, frt_pkg::OFS_STATUS);
  endsequence

  property p_low_write_reload;
    @(posedge CLK_SYS) disable iff (RST)
    CE && wr && WB_SEL_I[0] && is_ofs(WB_ADR_I, frt_pkg::OFS_SHADOW_LOW)
    |=> s_reg.cnt == 16'hFFFC;
  endproperty
  a_low_write_reload: assert property (p_low_write_reload) else $error("no reload"); // [RQ5]

  property p_wrap_flag;
    @(posedge CLK_SYS) disable iff (RST)
    tick && s_reg.cnt == 16'hFFFF && !wr |=> s_reg.flag && s_reg.cnt == 16'h0000;
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("wrap lost"); // [RQ10]

  property p_step_one;
    @(posedge CLK_SYS) disable iff (RST)
    tick && !wr |=> s_reg.cnt == $past(s_reg.cnt) + 16'h0001;
  endproperty
  a_step_one: assert property (p_step_one) else $error("bad step"); // [RQ20]

  property p_hi_latch;
    @(posedge CLK_SYS) disable iff (RST)
    s_hi_read and (!s_reg.latch_valid) |=> s_reg.latch_valid
      && s_reg.latch == $past(s_reg.cnt[7:0]);
  endproperty
  a_hi_latch: assert property (p_hi_latch) else $error("no latch"); // [RQ8]

  property p_live_low;
    @(posedge CLK_SYS) disable iff (RST)
    CE && rd && !s_reg.latch_valid && is_ofs(WB_ADR_I, frt_pkg::OFS_COUNT_LOW)
    |=> WB_ACK_O && WB_DAT_O[7:0] == $past(s_reg.cnt[7:0]);
  endproperty
  a_live_low: assert property (p_live_low) else $error("stale low"); // [RQ9]

  property p_clear_needs_arm;
    @(posedge CLK_SYS) disable iff (RST)
    $fell(s_reg.flag) |-> $past(s_reg.armed) && $past(acc);
  endproperty
  a_clear_needs_arm: assert property (p_clear_needs_arm) else $error("early clear"); // [RQ12]

  property p_status_arms;
    @(posedge CLK_SYS) disable iff (RST)
    s_status_seen |=> s_reg.armed || !s_reg.flag;
  endproperty
  a_status_arms: assert property (p_status_arms) else $error("not armed"); // [RQ12]

  property p_shadow_keeps;
    @(posedge CLK_SYS) disable iff (RST)
    CE && acc && s_reg.flag && is_ofs(WB_ADR_I, frt_pkg::OFS_SHADOW_LOW) |=> s_reg.flag;
  endproperty
  a_shadow_keeps: assert property (p_shadow_keeps) else $error("shadow cleared"); // [RQ13]

  property p_stop_freeze;
    @(posedge CLK_SYS) disable iff (RST)
    DEEP_STOP && !wr |=> $stable(s_reg.cnt);
  endproperty
  a_stop_freeze: assert property (p_stop_freeze) else $error("moved in stop"); // [RQ15]

  property p_irq_gate;
    @(posedge CLK_SYS) disable iff (RST)
    CE ##1 TIMER_IRQ |-> $past(s_reg.irq_en) && !$past(GLOBAL_IRQ_MASK);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("ungated request"); // [RQ11]

  // [RQ14] idle keeps counting
  property p_idle_runs;
    @(posedge CLK_SYS) disable iff (RST)
    IDLE_SLEEP && CE && !DEEP_STOP && s_reg.psel == frt_pkg::PSEL_DIV8 &&
      s_reg.presc == 3'h7 && !wr |=> s_reg.cnt != $past(s_reg.cnt);
  endproperty
  a_idle_runs: assert property (p_idle_runs) else $error("idle stalled"); // [RQ14]

endmodule
`default_nettype wire

// file: design/frt_pkg.sv
/*
  Constants for the 16-bit free-running timer: register offsets,
  field positions, reset values and prescaler encodings.
  Assumes a 32-bit classic Wishbone bus with byte addressing.
*/
package frt_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_COUNT_HIGH   = 8'h00;
  localparam logic [7:0] OFS_COUNT_LOW    = 8'h04;
  localparam logic [7:0] OFS_SHADOW_HIGH  = 8'h08;
  localparam logic [7:0] OFS_SHADOW_LOW   = 8'h0C;
  localparam logic [7:0] OFS_STATUS       = 8'h10;
  localparam logic [7:0] OFS_FIRST_CTRL   = 8'h14;
  localparam logic [7:0] OFS_SECOND_CTRL  = 8'h18;
  // ==========================================================
  // Field positions
  localparam int BIT_ROLLOVER_FLAG   = 0;
  localparam int BIT_ROLLOVER_IRQ_EN = 0;
  localparam int BIT_PSEL_LO         = 0;
  localparam int BIT_EDGE_SELECT     = 2;
  // ==========================================================
  // Value after reset and reload, and the last count before wrap
  localparam logic [15:0] COUNT_RELOAD = 16'hFFFC;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
  // ==========================================================
  // Prescale select encodings and divider masks
  localparam logic [1:0] PSEL_DIV2 = 2'h0;
  localparam logic [1:0] PSEL_DIV4 = 2'h1;
  localparam logic [1:0] PSEL_DIV8 = 2'h2;
  localparam logic [1:0] PSEL_EXT  = 2'h3;
  localparam logic [2:0] MASK_DIV2 = 3'h1;
  localparam logic [2:0] MASK_DIV4 = 3'h3;
  localparam logic [2:0] MASK_DIV8 = 3'h7;
endpackage

// file: bench/frt_ext_src.sv
/*
  Model of the source on the external count pin.
  Assumes the bench calls drive from one process at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module frt_ext_src (
  input  wire logic clk,
  output var  logic pin
);
  // ==========================================
  // Pin level
  // Idles low between bursts
  initial pin = 1'b0;
  task automatic drive(input logic v);
    @(posedge clk);
    pin <= v;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
/*
  Self-checking bench for the free-running timer.
  Assumes frt_pkg, frt_timer and frt_ext_src compile first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys, rst, ce, cyc, stb, we, mask, idle, stop, ext_pin, irq, ack;
  logic [3:0]  sel, wsel;
  logic [7:0]  adr;
  logic [31:0] dat_i, dat_o;
  int          n_fail, n_checks;
  // ==========================================
  // Design and count source
  frt_timer frt_timer_inst (
    .CLK_SYS(clk_sys), .RST(rst), .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .EXT_COUNT_IN(ext_pin),
    .GLOBAL_IRQ_MASK(mask), .IDLE_SLEEP(idle), .DEEP_STOP(stop), .TIMER_IRQ(irq)
  );
  frt_ext_src frt_ext_src_inst (.clk(clk_sys), .pin(ext_pin));
  // Clock of 5 ns
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ==========================================
  // Shared tasks
  task automatic report_and_stop();
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One classic bus cycle, bounded wait for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] r);
    int i;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= wsel;
    adr <= a;
    dat_i <= {24'h000000, d};
    i = 0;
    do
    begin
      @(posedge clk_sys);
      i++;
    end
    while (ack !== 1'b1 && i < 20);
    r = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
    begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    logic [7:0] h, l;
    wb(1'b0, a, 8'h00, h);
    wb(1'b0, a + 8'h04, 8'h00, l);
    v = {h, l};
  endtask
  task automatic flag(input logic e);
    logic [7:0] r;
    wb(1'b0, frt_pkg::OFS_STATUS, 8'h00, r);
    chk("flag", {15'h0000, r[0]}, {15'h0000, e});
  endtask
  // Lets the count run for n edges
  task automatic run(input int n);
    @(posedge clk_sys);
    stop <= 1'b0;
    repeat (n) @(posedge clk_sys);
    stop <= 1'b1;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    logic [15:0] v;
    logic [7:0]  r;
    rd16(frt_pkg::OFS_COUNT_HIGH, v);
    chk("count", v, frt_pkg::COUNT_RELOAD);
    rd16(frt_pkg::OFS_SHADOW_HIGH, v);
    chk("shadow", v, frt_pkg::COUNT_RELOAD);
    flag(1'b0);
    wb(1'b1, 8'h1C, 8'hFF, r);
    wb(1'b0, 8'h1C, 8'h00, r);
    chk("unmapped", {8'h00, r}, 16'h0000);
  endtask
  task automatic t_latch();
    logic [15:0] v;
    logic [7:0]  r;
    wb(1'b0, frt_pkg::OFS_COUNT_HIGH, 8'h00, r);
    run(64);
    wb(1'b0, frt_pkg::OFS_COUNT_HIGH, 8'h00, r);
    chk("high", {8'h00, r}, 16'h0000);
    wb(1'b0, frt_pkg::OFS_COUNT_LOW, 8'h00, r);
    chk("latched low", {8'h00, r}, 16'h00FC);
    wb(1'b0, frt_pkg::OFS_COUNT_LOW, 8'h00, r);
    chk("live low", {8'h00, r}, 16'h001C);
    rd16(frt_pkg::OFS_SHADOW_HIGH, v);
    chk("frozen", v, frt_pkg::COUNT_RELOAD + 16'h0020);
    flag(1'b1);
  endtask
  task automatic t_irq();
    logic [7:0] r;
    @(posedge clk_sys);
    mask <= 1'b1;
    wb(1'b1, frt_pkg::OFS_FIRST_CTRL, 8'h01, r);
    repeat (3) @(posedge clk_sys);
    chk("masked irq", {15'h0000, irq}, 16'h0000);
    mask <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("irq", {15'h0000, irq}, 16'h0001);
  endtask
  task automatic t_clear();
    logic [15:0] v;
    logic [7:0]  r;
    wb(1'b0, frt_pkg::OFS_SHADOW_LOW, 8'h00, r);
    flag(1'b1);
    wb(1'b0, frt_pkg::OFS_SHADOW_LOW, 8'h00, r);
    flag(1'b1);
    wb(1'b1, frt_pkg::OFS_COUNT_LOW, 8'h5A, r);
    flag(1'b0);
    chk("irq off", {15'h0000, irq}, 16'h0000);
    rd16(frt_pkg::OFS_COUNT_HIGH, v);
    chk("reload", v, frt_pkg::COUNT_RELOAD);
  endtask
  task automatic t_presc();
    logic [15:0] v;
    logic [7:0]  r;
    for (int p = 1; p <= 2; p++)
    begin
      wb(1'b1, frt_pkg::OFS_SECOND_CTRL, {6'h00, 2'(p)}, r);
      wb(1'b1, frt_pkg::OFS_SHADOW_LOW, 8'h00, r);
      idle <= (p == 2);
      run(64);
      rd16(frt_pkg::OFS_COUNT_HIGH, v);
      chk("divided", v, frt_pkg::COUNT_RELOAD + 16'(32 >> p));
    end
  endtask
  task automatic t_ext();
    logic [15:0] v;
    logic [7:0]  r;
    stop <= 1'b0;
    for (int e = 1; e >= 0; e--)
    begin
      wb(1'b1, frt_pkg::OFS_SECOND_CTRL, {5'h00, 1'(e), frt_pkg::PSEL_EXT}, r);
      wb(1'b1, frt_pkg::OFS_COUNT_LOW, 8'h00, r);
      repeat (4)
      begin
        frt_ext_src_inst.drive(1'b1);
        frt_ext_src_inst.drive(1'b0);
      end
      frt_ext_src_inst.drive(1'b1);
      repeat (8) @(posedge clk_sys);
      rd16(frt_pkg::OFS_COUNT_HIGH, v);
      chk("ext", v, frt_pkg::COUNT_RELOAD + 16'(4 + e));
      frt_ext_src_inst.drive(1'b0);
    end
  endtask
  // Enable low freezes the count; a write without byte lane 0 is ignored
  task automatic t_ce();
    logic [15:0] v;
    logic [7:0]  r;
    @(posedge clk_sys);
    ce <= 1'b0;
    run(16);
    ce <= 1'b1;
    rd16(frt_pkg::OFS_SHADOW_HIGH, v);
    chk("held by enable", v, frt_pkg::COUNT_RELOAD + 16'h0008);
    wsel = 4'hE;
    wb(1'b1, frt_pkg::OFS_SHADOW_LOW, 8'h00, r);
    wsel = 4'hF;
    rd16(frt_pkg::OFS_SHADOW_HIGH, v);
    chk("lane 0 off write", v, frt_pkg::COUNT_RELOAD + 16'h0008);
  endtask
  // Reset in mid-run restarts from the reset count with the flag clear
  task automatic t_rst2();
    logic [15:0] v;
    @(posedge clk_sys);
    rst <= 1'b1;
    stop <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd16(frt_pkg::OFS_COUNT_HIGH, v);
    chk("count after reset", v, frt_pkg::COUNT_RELOAD);
    flag(1'b0);
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    {rst, stop} = 2'b11;
    {cyc, stb, we, mask, idle} = 5'h00;
    ce = 1'b1;
    sel = 4'hF;
    wsel = 4'hF;
    adr = 8'h00;
    dat_i = 32'h00000000;
    n_fail = 0;
    n_checks = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_latch();
    t_irq();
    t_clear();
    t_presc();
    t_ce();
    t_ext();
    t_rst2();
    report_and_stop();
  end
endmodule
`default_nettype wire
